// *** core/rtckac_device.sv ***
// Device end of the keyed real-time clock: registers, counters, alarm and calibration.
// ==========================================================
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rtckac_device
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    rtckac_sfr_if.device sfr,
    output logic cal_pin_out,
    output logic cal_pin_oe
);
    import rtckac_pkg::*;

    typedef struct packed {
        logic [7:0] key;
        rtckac_pwr_e power;
        logic iton;
        logic alarm;
        logic stop;
        logic [1:0] tbase;
        logic longhr;
        logic midnight;
        logic [7:0] cfg_shadow;
        logic cfg_pend;
        logic [7:0] alarm_interval;
        logic [7:0] alarm_interval_shadow;
        logic alarm_interval_pend;
        logic [7:0] hund;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] itc;
        logic it_held;
        logic [7:0] tick_div;
        logic [14:0] xphase;
        logic [7:0] nom;
        logic [7:0] temp;
        logic [7:0] pincfg;
        logic pending;
        logic irq_req;
        logic wake;
        logic [7:0] rdata;
        logic cal_out;
        logic cal_oe;
    } rtckac_dev_s;

    rtckac_dev_s q;
    rtckac_dev_s n;
    logic xtal_tick;
    logic cnt_tick;
    logic fast;
    logic signed [8:0] comp_sum;
    logic b128;
    logic b1;
    logic bmin;
    logic bhour;
    logic midn;
    logic base;
    logic alarm_ev;
    logic slow;
    logic [7:0] itc_inc;
    logic [7:0] cfg_rd;
    logic [7:0] rd_mux;

    assign fast = q.pincfg[PIN_FSEL+1] && (q.power != deepest_sleep_state);
    assign comp_sum = $signed({q.nom[7], q.nom}) + $signed({q.temp[7], q.temp});

    // ==========================================================
    // Tick sources: true crystal rate and counting rate.
    rtckac_pace u_xtal
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .comp_lsb(comp_sum),
        .fast(1'b0),
        .tick(xtal_tick)
    );

    rtckac_pace u_count
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .comp_lsb(comp_sum),
        .fast(fast),
        .tick(cnt_tick)
    );

    // ==========================================================
    // Next state.
    always_comb
    begin
        n = q;
        alarm_ev = 1'b0;
        base = 1'b0;
        b128 = cnt_tick && (q.tick_div == TICK_DIV_LAST);
        b1 = b128 && (q.hund == SUB_LAST);
        bmin = b1 && (q.sec == MINSEC_LAST);
        bhour = bmin && (q.min == MINSEC_LAST);
        midn = bhour && (q.hour == (q.longhr ? HOUR_LAST_LONG : HOUR_LAST_SHORT));
        slow = b128;
        itc_inc = q.itc + 8'h01;
        if (cnt_tick)
        begin
            n.tick_div = q.tick_div + 8'h01;
        end
        if (xtal_tick)
        begin
            n.xphase = q.xphase + 15'h0001;
        end
        if (b128)
        begin
            n.hund = b1 ? RESET_BYTE : q.hund + 8'h01;
        end
        if (b1)
        begin
            n.sec = bmin ? RESET_BYTE : q.sec + 8'h01;
        end
        if (bmin)
        begin
            n.min = bhour ? RESET_BYTE : q.min + 8'h01;
        end
        if (bhour)
        begin
            n.hour = midn ? RESET_BYTE : q.hour + 8'h01;
        end
        unique case (q.tbase)
            2'h0: base = b128;
            2'h1: base = b1;
            2'h2: base = bmin;
            2'h3: base = bhour;
        endcase
        if (!q.iton)
        begin
            n.itc = RESET_BYTE;
            n.it_held = 1'b0;
        end
        else if (base && !q.it_held)
        begin
            n.itc = itc_inc;
            if (itc_inc == q.alarm_interval)
            begin
                alarm_ev = 1'b1;
                n.itc = RESET_BYTE;
                n.it_held = q.stop;
            end
        end
        if (slow && q.cfg_pend)
        begin
            n.cfg_pend = 1'b0;
            n.iton = q.cfg_shadow[CFG_ITON];
            n.stop = q.cfg_shadow[CFG_STOP];
            n.tbase = q.cfg_shadow[CFG_TBASE+:2];
            n.longhr = q.cfg_shadow[CFG_LONGHR];
        end
        if (slow && q.alarm_interval_pend)
        begin
            n.alarm_interval_pend = 1'b0;
            n.alarm_interval = q.alarm_interval_shadow;
        end
        if (sfr.wr)
        begin
            if (rtckac_key_for(sfr.addr) != KEY_NONE)
            begin
                n.key = KEY_NONE;
            end
            case (sfr.addr)
                ADDR_KEY: n.key = sfr.wdata;
                ADDR_CONFIG:
                begin
                    n.cfg_shadow = sfr.wdata;
                    n.cfg_pend = 1'b1;
                    n.midnight = q.midnight && sfr.wdata[CFG_MIDNIGHT];
                    n.alarm = q.alarm && sfr.wdata[CFG_ALARM];
                end
                ADDR_ALARM_INTERVAL:
                begin
                    n.alarm_interval_shadow = sfr.wdata;
                    n.alarm_interval_pend = 1'b1;
                end
                ADDR_NOMCOMP: n.nom = sfr.wdata;
                ADDR_TEMPCOMP: n.temp = sfr.wdata;
                default:
                begin
                    if (q.key == rtckac_key_for(sfr.addr))
                    begin
                        if (sfr.addr == ADDR_HUND) n.hund = sfr.wdata;
                        if (sfr.addr == ADDR_SEC) n.sec = sfr.wdata;
                        if (sfr.addr == ADDR_MIN) n.min = sfr.wdata;
                        if (sfr.addr == ADDR_HOUR) n.hour = sfr.wdata;
                        if (sfr.addr == ADDR_PINCFG) n.pincfg = sfr.wdata;
                        if (sfr.addr == ADDR_POWER) n.power = rtckac_pwr_e'(sfr.wdata[1:0]);
                    end
                end
            endcase
        end
        if (midn)
        begin
            n.midnight = 1'b1;
        end
        if (alarm_ev)
        begin
            n.alarm = 1'b1;
        end
        if (sfr.irq_ack && sfr.irq_enable)
        begin
            n.pending = 1'b0;
        end
        if (midn || alarm_ev)
        begin
            n.pending = 1'b1;
        end
        n.irq_req = n.pending && sfr.irq_enable;
        n.wake = n.pending && (n.power == deepest_sleep_state);
        cfg_rd = RESET_BYTE;
        cfg_rd[CFG_ITON] = q.iton;
        cfg_rd[CFG_ALARM] = q.alarm;
        cfg_rd[CFG_STOP] = q.stop;
        cfg_rd[CFG_TBASE+:2] = q.tbase;
        cfg_rd[CFG_LONGHR] = q.longhr;
        cfg_rd[CFG_MIDNIGHT] = q.midnight;
        case (sfr.addr)
            ADDR_CONFIG: rd_mux = cfg_rd;
            ADDR_HUND: rd_mux = q.hund;
            ADDR_SEC: rd_mux = q.sec;
            ADDR_MIN: rd_mux = q.min;
            ADDR_HOUR: rd_mux = q.hour;
            ADDR_ALARM_INTERVAL: rd_mux = q.alarm_interval;
            ADDR_KEY: rd_mux = q.key;
            ADDR_POWER: rd_mux = {6'h00, q.power};
            ADDR_NOMCOMP: rd_mux = q.nom;
            ADDR_TEMPCOMP: rd_mux = q.temp;
            ADDR_PINCFG: rd_mux = q.pincfg;
            default: rd_mux = RESET_BYTE;
        endcase
        if (sfr.rd)
        begin
            n.rdata = rd_mux;
        end
        n.cal_oe = q.pincfg[PIN_CALEN];
        unique case (q.pincfg[PIN_FSEL+:2])
            2'h0: n.cal_out = q.xphase[14];
            2'h1: n.cal_out = q.xphase[5];
            2'h2: n.cal_out = q.hund[4];
            2'h3: n.cal_out = q.xphase[0];
        endcase
        n.cal_out = n.cal_out && q.pincfg[PIN_CALEN];
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign sfr.rdata = q.rdata;
    assign sfr.irq_req = q.irq_req;
    assign sfr.wake = q.wake;
    assign cal_pin_out = q.cal_out;
    assign cal_pin_oe = q.cal_oe;
endmodule : rtckac_device
`default_nettype wire

// *** core/rtckac_host.sv ***
// Core end of the keyed real-time clock: APB command registers driving the register link.
`timescale 1ns/1ps
`default_nettype none
module rtckac_host
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    rtckac_sfr_if.host sfr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import rtckac_pkg::*;

    typedef enum logic [2:0] {st_idle, st_key, st_data, st_unkey, st_rd, st_cap} rtckac_host_e;

    typedef struct packed {
        rtckac_host_e st;
        logic [7:0] addr;
        logic [7:0] data;
        logic is_time;
        logic is_isr;
        logic [2:0] idx;
        logic [31:0] snap;
        logic [7:0] rd_data;
        logic [1:0] cause;
        logic irq_en;
        logic [7:0] sfr_addr;
        logic [7:0] sfr_wdata;
        logic sfr_wr;
        logic sfr_rd;
        logic irq_ack;
        logic [31:0] prdata;
        logic pready;
    } rtckac_host_s;

    rtckac_host_s q;
    rtckac_host_s n;
    logic acc_wr;
    logic [7:0] key;

    assign acc_wr = psel && penable && pwrite && q.pready;
    assign key = rtckac_key_for(q.addr);

    // ==========================================================
    // Next state.
    always_comb
    begin
        n = q;
        n.sfr_wr = 1'b0;
        n.sfr_rd = 1'b0;
        n.irq_ack = 1'b0;
        n.pready = psel && !penable;
        if (acc_wr && paddr == APB_CTRL)
        begin
            n.irq_en = pwdata[0];
        end
        if (acc_wr && paddr == APB_STAT)
        begin
            n.cause = q.cause & ~pwdata[STAT_CAUSE+:2];
        end
        unique case (q.st)
            st_idle:
            begin
                if (acc_wr && paddr == APB_CMD)
                begin
                    n.addr = pwdata[7:0];
                    n.data = pwdata[CMD_DATA+:8];
                    n.is_time = pwdata[CMD_TIME];
                    n.is_isr = 1'b0;
                    n.idx = 3'h0;
                    n.sfr_addr = pwdata[CMD_TIME] ? ADDR_HUND : pwdata[7:0];
                    if (pwdata[CMD_WRITE] && !pwdata[CMD_TIME])
                    begin
                        n.sfr_wr = 1'b1;
                        n.sfr_wdata = pwdata[CMD_DATA+:8];
                        n.st = st_data;
                        if (rtckac_key_for(pwdata[7:0]) != KEY_NONE)
                        begin
                            n.sfr_addr = ADDR_KEY;
                            n.sfr_wdata = rtckac_key_for(pwdata[7:0]);
                            n.st = st_key;
                        end
                    end
                    else
                    begin
                        n.sfr_rd = 1'b1;
                        n.st = st_rd;
                    end
                end
                else if (q.irq_en && sfr.irq_req)
                begin
                    n.irq_ack = 1'b1;
                    n.is_isr = 1'b1;
                    n.is_time = 1'b0;
                    n.addr = ADDR_CONFIG;
                    n.sfr_addr = ADDR_CONFIG;
                    n.sfr_rd = 1'b1;
                    n.st = st_rd;
                end
            end
            st_key:
            begin
                n.sfr_wr = 1'b1;
                n.sfr_addr = q.addr;
                n.sfr_wdata = q.data;
                n.st = st_data;
            end
            st_data:
            begin
                n.st = st_idle;
                if (key != KEY_NONE)
                begin
                    n.sfr_wr = 1'b1;
                    n.sfr_addr = ADDR_KEY;
                    n.sfr_wdata = KEY_NONE;
                    n.st = st_unkey;
                end
            end
            st_unkey: n.st = st_idle;
            st_rd: n.st = st_cap;
            st_cap:
            begin
                n.st = st_idle;
                if (q.is_isr)
                begin
                    n.cause = n.cause | {sfr.rdata[CFG_MIDNIGHT], sfr.rdata[CFG_ALARM]};
                    n.data = sfr.rdata;
                    n.data[CFG_MIDNIGHT] = 1'b0;
                    n.data[CFG_ALARM] = 1'b0;
                    n.sfr_wr = 1'b1;
                    n.sfr_wdata = n.data;
                    n.st = st_data;
                end
                else if (q.is_time)
                begin
                    n.idx = q.idx + 3'h1;
                    if (q.idx == 3'h4)
                    begin
                        n.idx = 3'h0;
                        if (sfr.rdata == q.snap[7:0])
                        begin
                            n.is_time = 1'b0;
                        end
                    end
                    else
                    begin
                        n.snap[{q.idx[1:0], 3'h0}+:8] = sfr.rdata;
                    end
                    if (n.is_time)
                    begin
                        n.sfr_addr = (n.idx == 3'h4) ? ADDR_HUND : ADDR_HUND + {5'h00, n.idx};
                        n.sfr_rd = 1'b1;
                        n.st = st_rd;
                    end
                end
                else
                begin
                    n.rd_data = sfr.rdata;
                end
            end
            default: n.st = st_idle;
        endcase
        if (psel && !penable)
        begin
            n.prdata = 32'h0000_0000;
            if (paddr == APB_STAT)
            begin
                n.prdata[7:0] = q.rd_data;
                n.prdata[STAT_BUSY] = q.st != st_idle || q.is_time;
                n.prdata[STAT_IRQ] = sfr.irq_req;
                n.prdata[STAT_WAKE] = sfr.wake;
                n.prdata[STAT_CAUSE+:2] = q.cause;
            end
            if (paddr == APB_CTRL) n.prdata[0] = q.irq_en;
            if (paddr == APB_TIME) n.prdata = q.snap;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign sfr.addr = q.sfr_addr;
    assign sfr.wdata = q.sfr_wdata;
    assign sfr.wr = q.sfr_wr;
    assign sfr.rd = q.sfr_rd;
    assign sfr.irq_ack = q.irq_ack;
    assign sfr.irq_enable = q.irq_en;
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = 1'b0;
endmodule : rtckac_host
`default_nettype wire

// *** core/rtckac_pace.sv ***
// Calibrated crystal-rate tick generator.
`timescale 1ns/1ps
`default_nettype none
module rtckac_pace
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic signed [8:0] comp_lsb,
    input wire logic fast,
    output logic tick
);
    import rtckac_pkg::*;

    typedef struct packed {
        logic [PACE_W-1:0] acc;
        logic tick;
    } rtckac_pace_s;

    rtckac_pace_s q;
    rtckac_pace_s n;
    longint clamped;
    longint step;
    longint sum;

    // ==========================================================
    // Phase accumulator.
    always_comb
    begin
        n = q;
        clamped = longint'(comp_lsb);
        if (clamped > COMP_LIMIT_LSB)
        begin
            clamped = COMP_LIMIT_LSB;
        end
        if (clamped < -COMP_LIMIT_LSB)
        begin
            clamped = -COMP_LIMIT_LSB;
        end
        step = PACE_BASE + PACE_LSB * clamped;
        if (fast)
        begin
            step = step * FAST_FACTOR;
        end
        sum = longint'(q.acc) + step;
        n.tick = 1'b0;
        n.acc = PACE_W'(sum);
        if (sum >= PACE_MOD)
        begin
            n.acc = PACE_W'(sum - PACE_MOD);
            n.tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign tick = q.tick;
endmodule : rtckac_pace
`default_nettype wire

// *** dv/rtc_keyed_alarm_calibration_test.sv ***
// Self-checking bench for the two clock ends joined by their link.
`timescale 1ns/1ps
`default_nettype none
module rtc_keyed_alarm_calibration_test;
    import rtckac_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic cal_pin_out;
    logic cal_pin_oe;
    logic [31:0] rv;
    logic [7:0] h;
    logic [7:0] v;
    logic [7:0] cfgs [3] = '{8'h00, 8'h20, 8'h05};
    logic [7:0] hours [3] = '{HOUR_LAST_SHORT, HOUR_LAST_LONG, 8'h05};
    int n;
    int failures = 0;
    int check_count = 0;
    rtckac_sfr_if link();
    always #4 ref_clk = ~ref_clk;
    rtckac_device rtckac_device_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr(link.device),
        .cal_pin_out(cal_pin_out), .cal_pin_oe(cal_pin_oe));
    rtckac_host rtckac_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr(link.host),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr());
    rtckac_link_asserts checker_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .wr(link.wr), .rd(link.rd),
        .irq_enable(link.irq_enable), .irq_ack(link.irq_ack), .irq_req(link.irq_req),
        .wake(link.wake));
    task automatic give_verdict();
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stall();
        failures++;
        $display("wrong value at %0t: no answer", $time);
        give_verdict();
    endtask : stall
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(negedge ref_clk);
            k++;
            if (k > 20)
                stall();
        end
        while (pready !== 1'b1);
        rv = prdata;
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmd(input logic [31:0] c);
        int k;
        k = 0;
        apb(1'b1, APB_CMD, c);
        do
        begin
            apb(1'b0, APB_STAT, 32'h00000000);
            k++;
            if (k > 50)
                stall();
        end
        while (rv[STAT_BUSY] !== 1'b0);
    endtask : cmd
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        cmd({15'h0000, 1'b1, d, a});
    endtask : put
    function automatic logic [1:0] cause_of(input int i);
        return (i < 2) ? 2'h2 : 2'h1;
    endfunction : cause_of
    initial
    begin
        void'($urandom(32'h40CE0F30));
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, APB_STAT, 32'h00000000);
        chk(rv, 32'h00000000);
        v = 8'($urandom());
        put(ADDR_NOMCOMP, v);
        put(ADDR_TEMPCOMP, ~v);
        cmd({24'h000000, ADDR_NOMCOMP});
        chk(rv[7:0], v);
        for (int f = 0; f < 4; f++)
        begin
            put(ADDR_PINCFG, {1'b1, 2'(f), 5'h00});
            chk(cal_pin_oe, 1'b1);
        end
        put(ADDR_PINCFG, 8'h00);
        chk({cal_pin_oe, cal_pin_out}, 2'h0);
        h = 8'($urandom_range(22));
        v = v % 8'h3C;
        put(ADDR_HOUR, h);
        put(ADDR_MIN, 8'h3A);
        put(ADDR_SEC, v);
        cmd(32'h00020000);
        apb(1'b0, APB_TIME, 32'h00000000);
        chk(rv[31:8], {h, 8'h3A, v});
        cmd({24'h000000, ADDR_KEY});
        chk(rv[7:0], KEY_NONE);
        apb(1'b1, APB_CTRL, 32'h00000001);
        put(ADDR_PINCFG, 8'h40);
        for (int i = 0; i < 3; i++)
        begin
            put(ADDR_ALARM_INTERVAL, 8'h02);
            put(ADDR_CONFIG, cfgs[i]);
            repeat (15700) @(posedge ref_clk);
            put(ADDR_HOUR, hours[i]);
            put(ADDR_MIN, MINSEC_LAST);
            put(ADDR_SEC, MINSEC_LAST);
            put(ADDR_HUND, SUB_LAST);
            n = 0;
            do
            begin
                apb(1'b0, APB_STAT, 32'h00000000);
                n++;
                if (n > 6000)
                    stall();
            end
            while (rv[12:11] === 2'h0);
            chk(rv[12:11], cause_of(i));
            apb(1'b1, APB_STAT, 32'h00001800);
            cmd(32'h00020000);
            apb(1'b0, APB_TIME, 32'h00000000);
            if (i < 2)
                chk(rv[31:24], 8'h00);
        end
        apb(1'b1, APB_CTRL, 32'h00000000);
        put(ADDR_HOUR, HOUR_LAST_SHORT);
        put(ADDR_MIN, MINSEC_LAST);
        put(ADDR_SEC, MINSEC_LAST);
        put(ADDR_HUND, SUB_LAST);
        n = 0;
        do
        begin
            cmd({24'h000000, ADDR_CONFIG});
            n++;
            if (n > 2000)
                stall();
        end
        while (rv[CFG_MIDNIGHT] !== 1'b1);
        put(ADDR_POWER, 8'h02);
        apb(1'b0, APB_STAT, 32'h00000000);
        chk(rv[10:9], 2'h2);
        apb(1'b1, APB_CTRL, 32'h00000001);
        repeat (20) @(posedge ref_clk);
        apb(1'b0, APB_STAT, 32'h00000000);
        chk(rv[12:9], 4'h8);
        give_verdict();
    end
endmodule : rtc_keyed_alarm_calibration_test
`default_nettype wire

// *** dv/rtckac_link_asserts.sv ***
// Checker of the register link between the two clock ends.
`timescale 1ns/1ps
`default_nettype none
module rtckac_link_asserts
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic irq_enable,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic wake
);
    import rtckac_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Link properties.
    sequence s_time_key;
        wr && addr == ADDR_KEY && wdata == KEY_TIME;
    endsequence
    sequence s_key_drop;
        wr && addr == ADDR_KEY && wdata == KEY_NONE;
    endsequence
    sequence s_flag_clear;
        wr && addr == ADDR_CONFIG && !wdata[CFG_MIDNIGHT] && !wdata[CFG_ALARM];
    endsequence
    a_key_dropped: assert property (s_time_key |-> ##[2:6] s_key_drop)
        else $error("key left set");
    a_irq_gated: assert property (irq_req |-> $past(irq_enable))
        else $error("request while disabled");
    a_ack_clears: assert property (irq_ack |-> irq_req ##1 !irq_req)
        else $error("pending not cleared");
    a_ack_reads: assert property (irq_ack |-> rd && addr == ADDR_CONFIG)
        else $error("cause not read");
    a_flags_cleared: assert property (irq_ack |-> ##[1:16] s_flag_clear)
        else $error("flags not cleared");
    a_wake_held: assert property (wake && !irq_ack && !(wr && addr == ADDR_POWER) |=> wake)
        else $error("wake dropped");
    a_wake_irq: assert property (wake && $past(irq_enable) |-> irq_req)
        else $error("wake without request");
    a_rdata_held: assert property (!$past(rd) && !$past(rd, 2) |-> $stable(rdata))
        else $error("read data moved");
endmodule : rtckac_link_asserts
`default_nettype wire

// *** shared/rtckac_pkg.sv ***
// Shared constants, types and decode for the keyed real-time clock.
package rtckac_pkg;
    // ==========================================================
    // Register offsets.
    localparam logic [7:0] ADDR_CONFIG = 8'hA1;
    localparam logic [7:0] ADDR_HUND = 8'hA2;
    localparam logic [7:0] ADDR_SEC = 8'hA3;
    localparam logic [7:0] ADDR_MIN = 8'hA4;
    localparam logic [7:0] ADDR_HOUR = 8'hA5;
    localparam logic [7:0] ADDR_ALARM_INTERVAL = 8'hA6;
    localparam logic [7:0] ADDR_KEY = 8'hC1;
    localparam logic [7:0] ADDR_POWER = 8'hC5;
    localparam logic [7:0] ADDR_NOMCOMP = 8'hF6;
    localparam logic [7:0] ADDR_TEMPCOMP = 8'hF7;
    localparam logic [7:0] ADDR_PINCFG = 8'hFF;
    // ==========================================================
    // Keys, field positions and reset values.
    localparam logic [7:0] KEY_POWER = 8'hA7;
    localparam logic [7:0] KEY_TIME = 8'hEA;
    localparam logic [7:0] KEY_NONE = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int CFG_ITON = 0;
    localparam int CFG_ALARM = 1;
    localparam int CFG_STOP = 2;
    localparam int CFG_TBASE = 3;
    localparam int CFG_LONGHR = 5;
    localparam int CFG_MIDNIGHT = 6;
    localparam int PIN_FSEL = 5;
    localparam int PIN_CALEN = 7;
    localparam logic [7:0] SUB_LAST = 8'h7F;
    localparam logic [7:0] MINSEC_LAST = 8'h3B;
    localparam logic [7:0] HOUR_LAST_SHORT = 8'h17;
    localparam logic [7:0] HOUR_LAST_LONG = 8'hFF;
    localparam logic [7:0] TICK_DIV_LAST = 8'hFF;
    // ==========================================================
    // Timing.
    localparam longint REF_HZ = 125_000_000;
    localparam longint XTAL_HZ = 32_768;
    localparam longint FAST_FACTOR = 125;
    localparam longint COMP_LSB_PPM = 2;
    localparam longint COMP_LIMIT_PPM = 248;
    localparam int COMP_LIMIT_LSB = int'(COMP_LIMIT_PPM / COMP_LSB_PPM);
    localparam longint PACE_SCALE = 15_625;
    localparam longint PACE_MOD = REF_HZ * PACE_SCALE;
    localparam longint PACE_BASE = XTAL_HZ * PACE_SCALE;
    localparam longint PACE_LSB = PACE_BASE * COMP_LSB_PPM / 1_000_000;
    localparam int PACE_W = 41;
    // ==========================================================
    // Host register map.
    localparam logic [11:0] APB_CMD = 12'h000;
    localparam logic [11:0] APB_STAT = 12'h004;
    localparam logic [11:0] APB_CTRL = 12'h008;
    localparam logic [11:0] APB_TIME = 12'h00C;
    localparam int CMD_DATA = 8;
    localparam int CMD_WRITE = 16;
    localparam int CMD_TIME = 17;
    localparam int STAT_BUSY = 8;
    localparam int STAT_IRQ = 9;
    localparam int STAT_WAKE = 10;
    localparam int STAT_CAUSE = 11;

    typedef enum logic [1:0] {full_power_state, battery_power_state, deepest_sleep_state,
        spare_power_state} rtckac_pwr_e;

    // Returns the key a write to this register needs, or KEY_NONE.
    function automatic logic [7:0] rtckac_key_for(input logic [7:0] addr);
        logic [7:0] k;
        k = KEY_NONE;
        if (addr == ADDR_HUND || addr == ADDR_SEC || addr == ADDR_MIN || addr == ADDR_HOUR
            || addr == ADDR_PINCFG)
        begin
            k = KEY_TIME;
        end
        if (addr == ADDR_POWER)
        begin
            k = KEY_POWER;
        end
        return k;
    endfunction : rtckac_key_for
endpackage : rtckac_pkg

// *** shared/rtckac_sfr_if.sv ***
// Special function register link between the core and the clock.
`timescale 1ns/1ps
`default_nettype none
interface rtckac_sfr_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic irq_enable;
    logic irq_ack;
    logic irq_req;
    logic wake;
    modport device (input addr, input wdata, input wr, input rd, input irq_enable,
        input irq_ack, output rdata, output irq_req, output wake);
    modport host (output addr, output wdata, output wr, output rd, output irq_enable,
        output irq_ack, input rdata, input irq_req, input wake);
endinterface : rtckac_sfr_if
`default_nettype wire
